// ---- cbl_defs.svh ----
/*
  Constants of the boot-time configuration loader: register window, EEPROM
  image layout, serial command and link timing counts.
  Assumes the link clock runs from an internal oscillator of 64 ns period.
*/
`ifndef CBL_DEFS_SVH
`define CBL_DEFS_SVH

// Register window filled from the EEPROM
`define CBL_REG_FIRST        8'h0a
`define CBL_REG_LAST         8'h1c
`define CBL_NUM_REGS         (`CBL_REG_LAST - `CBL_REG_FIRST + 1)
`define CBL_ACT_BIT          6

// EEPROM image layout, byte addresses
`define CBL_SLOT_STRIDE      64
`define CBL_COPY1_OFS        20
`define CBL_COPY2_OFS        40
`define CBL_LAST_COPY        2'h2

// Serial memory read command
`define CBL_READ_CMD         8'h03
`define CBL_ADDR_BITS        16

// Link timing, oscillator period and documented times
`define CBL_OSC_PERIOD_NS    64
`define CBL_SCK_TARGET_KHZ   2000
`define CBL_SCK_HALF_NS      (1000000 / (2 * `CBL_SCK_TARGET_KHZ))
`define CBL_CS_LEAD_NS       400
`define CBL_CS_HOLD_NS       100
`define CBL_CS_HIGH_NS       500

// Derived cycle counts, least times rounded up
`define CBL_SCK_HALF_CYC     ((`CBL_SCK_HALF_NS + `CBL_OSC_PERIOD_NS - 1) / `CBL_OSC_PERIOD_NS)
`define CBL_CS_LEAD_CYC      ((`CBL_CS_LEAD_NS + `CBL_OSC_PERIOD_NS - 1) / `CBL_OSC_PERIOD_NS)
`define CBL_CS_HOLD_CYC      ((`CBL_CS_HOLD_NS + `CBL_OSC_PERIOD_NS - 1) / `CBL_OSC_PERIOD_NS)
`define CBL_CS_HIGH_CYC      ((`CBL_CS_HIGH_NS + `CBL_OSC_PERIOD_NS - 1) / `CBL_OSC_PERIOD_NS)

`endif

// ---- cbl_eeprom_model.sv ----
/*
  Serial EEPROM model for the loader bench: mode 0, read command, 16-bit
  start address, then sequential bytes for as long as the clock runs.
  Assumes the bench fills mem directly and that only reads are issued.
*/
`timescale 1ns/1ps

module cbl_eeprom_model (
  // Serial slave pins
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  // Observation of the last burst
  output logic [7:0]       cmd_seen,
  output logic [15:0]      addr_seen,
  output logic [15:0]      bits_seen,
  output logic [15:0]      n_starts
);
  // 4 kbit image: eight slots of three copies
  logic [7:0] mem [0:511];
  int         pos;

  // Idle line and counters at time zero
  initial begin
    miso      = 1'b0;
    cmd_seen  = 8'h00;
    addr_seen = 16'h0000;
    bits_seen = 16'h0000;
    n_starts  = 16'h0000;
  end

  // New frame restarts the bit count
  always @(negedge cs_n) begin
    bits_seen = 16'h0000;
    n_starts  = n_starts + 16'h0001;
  end

  // Released line shows the inverse of its last level
  always @(posedge cs_n) begin
    miso = ~miso;
  end

  // Command and address taken MSB first on the rising clock
  always @(posedge sck) begin
    if (!cs_n) begin
      if (bits_seen < 16'h0008) cmd_seen = {cmd_seen[6:0], mosi};
      else if (bits_seen < 16'h0018) addr_seen = {addr_seen[14:0], mosi};
      bits_seen = bits_seen + 16'h0001;
    end
  end

  // Data MSB first after each falling clock, address advancing per byte
  always @(negedge sck) begin
    if (!cs_n) begin
      if (bits_seen >= 16'h0018) begin
        pos = int'(bits_seen) - 24;
        #10 miso = mem[(int'(addr_seen) + pos / 8) % 512][7 - pos % 8];
      end else begin
        miso = ~miso; // Not driven yet, keep it moving
      end
    end
  end
endmodule // cbl_eeprom_model

// ---- cbl_loader.sv ----
/*
  Boot-time configuration loader: on reset release latches the slot pins,
  burst-reads three copies of the slot image from a serial EEPROM, runs on
  the first copy and then applies a bitwise two-of-three vote.
  Assumes clk_osc is the free-running internal oscillator (64 ns) and that
  rst_n is synchronous to clk_sys; EEPROM pins are plain, no tri-state.
*/
// Contract
// - Registers 0x0a through 0x1c are filled from EEPROM bytes of the slot.
// - Three select pins give binary index; slot equals index plus one, up to eight.
// - Slot choice latched only at reset release, later pin changes ignored.
// - Every reset release starts fetching the selected configuration over serial lines; here only while interface_select_pin is high.
// - Each copy is one sequential burst read, start to end address.
// - After first copy completes, registers load it and operation begins.
// - Second and third copies read back to back, then bitwise majority applied.
// - Address is 64 times (slot-1) plus 0, 20 or 40; offsets map upward.
// - One, two, four kilobit memories give two, four, eight slots only.
// - Device makes the serial clock itself, about 2 MHz, from its oscillator.
// - Operating activity follows bit 6 of register 0x0a once loaded.
`timescale 1ns/1ps
`include "cbl_defs.svh"

module cbl_loader #(
  parameter int        NUM_REGS = `CBL_NUM_REGS,
  parameter int        ADDR_W   = `CBL_ADDR_BITS,
  parameter logic [7:0] READ_CMD = `CBL_READ_CMD
) (
  // System clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // Internal oscillator, clocks the EEPROM link
  input  wire logic                       clk_osc,
  // Slot selection and mode strap pins
  input  wire logic                       config_sel_high,
  input  wire logic                       config_sel_mid,
  input  wire logic                       config_sel_low,
  input  wire logic                       interface_select_pin,
  // EEPROM serial master
  output logic                            ee_cs_n,
  output logic                            ee_sck,
  output logic                            ee_mosi,
  input  wire logic                       ee_miso,
  // Loaded configuration and status
  output logic [NUM_REGS-1:0][7:0]        cfg_regs,
  output logic                            activation_bit,
  output cbl_pkg::cbl_status_t            status,
  output logic [2:0]                      slot_index
);

  localparam int HDR   = 8 + ADDR_W;
  localparam int TOTAL = HDR + 8 * NUM_REGS;
  localparam int BW    = $clog2(TOTAL);
  localparam int HALF  = `CBL_SCK_HALF_CYC;

  // ---------------- system domain ----------------
  cbl_pkg::cbl_sel_t            sel_s1, sel_s2;
  logic                         ifs_s1, ifs_s2;
  logic                         rel_prev_reg;
  logic                         rel_pulse;
  logic [2:0]                   slot_reg;
  logic                         start_tog_reg;
  logic                         rq_s1, rq_s2;
  logic                         ack_tog_reg;
  logic                         take;
  logic                         take_last;
  logic [NUM_REGS-1:0][7:0]     copy_a, copy_b, copy_c;
  logic [NUM_REGS-1:0][7:0]     cfg_reg;
  logic                         apply0_reg, apply2_reg;
  logic                         act_reg;
  cbl_pkg::cbl_status_t         stat_reg;
  cbl_pkg::cbl_rx_byte_t        rx_word;

  // ---------------- link domain ----------------
  logic                         ors1, ors2;
  logic                         st_s1, st_s2, st_seen;
  logic                         ak_s1, ak_s2;
  logic                         mi_s1, mi_s2;
  cbl_pkg::cbl_link_state_t     lstate;
  logic [1:0]                   copy_reg;
  logic [3:0]                   hc;
  logic [3:0]                   wait_cnt;
  logic                         sck_reg, cs_n_reg;
  logic [BW-1:0]                bit_cnt;
  logic [HDR-1:0]               tx_shift;
  logic [7:0]                   rx_shift;
  logic                         req_tog;
  logic [2:0]                   slot_l;
  logic [ADDR_W-1:0]            ee_addr;
  logic [BW-1:0]                data_idx;
  logic                         data_phase, stall, sck_tick, sck_rise, sck_fall;

  // Two-flop synchronisers for the asynchronous pins
  always_ff @(posedge clk_sys) begin
    sel_s1 <= '{high: config_sel_high, mid: config_sel_mid, low: config_sel_low};
    sel_s2 <= sel_s1;
    ifs_s1 <= interface_select_pin;
    ifs_s2 <= ifs_s1;
    rq_s1  <= req_tog;
    rq_s2  <= rq_s1;
  end

  // Reset release detector, first cycle out of reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) rel_prev_reg <= 1'b0;
    else        rel_prev_reg <= 1'b1;
  end
  assign rel_pulse = !rel_prev_reg;

  // Slot latched only at release, index from pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n)         slot_reg <= 3'h0;
    else if (rel_pulse) slot_reg <= sel_s2;
  end

  // Fetch start toggle, skipped when host slave mode is strapped
  always_ff @(posedge clk_sys) begin
    if (!rst_n)                   start_tog_reg <= 1'b0;
    else if (rel_pulse && ifs_s2) start_tog_reg <= ~start_tog_reg;
  end

  // Byte handshake from the link side
  assign take      = (rq_s2 != ack_tog_reg);
  assign take_last = take && (rx_word.offset == 5'(NUM_REGS - 1));
  always_ff @(posedge clk_sys) begin
    if (!rst_n)    ack_tog_reg <= 1'b0;
    else if (take) ack_tog_reg <= rq_s2;
  end

  // Copy staging arrays, indexed by offset within the copy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      copy_a <= '0;
      copy_b <= '0;
      copy_c <= '0;
    end else if (take) begin
      case (rx_word.copy)
        2'h0:    copy_a[rx_word.offset] <= rx_word.data;
        2'h1:    copy_b[rx_word.offset] <= rx_word.data;
        default: copy_c[rx_word.offset] <= rx_word.data;
      endcase
    end
  end

  // Apply strobes one cycle after the last byte of the first and of the third copy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      apply0_reg <= 1'b0;
      apply2_reg <= 1'b0;
    end else begin
      apply0_reg <= take_last && (rx_word.copy == 2'h0);
      apply2_reg <= take_last && (rx_word.copy == `CBL_LAST_COPY);
    end
  end

  // Operating registers: first copy, then one voted update
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_reg <= '0;
      act_reg <= 1'b0;
    end else if (apply0_reg) begin
      cfg_reg <= copy_a;
      act_reg <= copy_a[0][`CBL_ACT_BIT];
    end else if (apply2_reg) begin
      cfg_reg <= (copy_a & copy_b) | (copy_a & copy_c) | (copy_b & copy_c);
      act_reg <= (copy_a[0][`CBL_ACT_BIT] & copy_b[0][`CBL_ACT_BIT])
               | (copy_a[0][`CBL_ACT_BIT] & copy_c[0][`CBL_ACT_BIT])
               | (copy_b[0][`CBL_ACT_BIT] & copy_c[0][`CBL_ACT_BIT]);
    end
  end

  // Status flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stat_reg <= '0;
    end else begin
      if (rel_pulse && ifs_s2) stat_reg.busy <= 1'b1;
      else if (apply2_reg)     stat_reg.busy <= 1'b0;
      if (apply0_reg) stat_reg.loaded <= 1'b1;
      if (apply2_reg) stat_reg.voted  <= 1'b1;
    end
  end

  assign cfg_regs       = cfg_reg;
  assign activation_bit = act_reg;
  assign status         = stat_reg;
  assign slot_index     = slot_reg;

  // ================= link domain, clk_osc =================

  // Reset, start, ack and data-in synchronisers
  always_ff @(posedge clk_osc) begin
    ors1  <= rst_n;
    ors2  <= ors1;
    st_s1 <= start_tog_reg;
    st_s2 <= st_s1;
    ak_s1 <= ack_tog_reg;
    ak_s2 <= ak_s1;
    mi_s1 <= ee_miso;
    mi_s2 <= mi_s1;
  end

  // Burst addressing per slot and copy
  always_comb begin
    ee_addr = ADDR_W'(slot_l) * ADDR_W'(`CBL_SLOT_STRIDE);
    if (copy_reg == 2'h1)      ee_addr = ee_addr + ADDR_W'(`CBL_COPY1_OFS);
    else if (copy_reg == 2'h2) ee_addr = ee_addr + ADDR_W'(`CBL_COPY2_OFS);
  end

  // Serial clock events, held low while a byte awaits its ack
  assign data_phase = (bit_cnt >= BW'(HDR));
  assign stall      = data_phase && !sck_reg && (req_tog != ak_s2);
  assign sck_tick   = (lstate == cbl_pkg::CBL_XFER) && !stall && (hc == 4'(HALF - 1));
  assign sck_rise   = sck_tick && !sck_reg;
  assign sck_fall   = sck_tick && sck_reg;
  assign data_idx   = bit_cnt - BW'(HDR);

  // Burst sequencer: lead, transfer, hold, gap, three copies
  always_ff @(posedge clk_osc) begin
    if (!ors2) begin
      lstate   <= cbl_pkg::CBL_IDLE;
      st_seen  <= 1'b0;
      copy_reg <= 2'h0;
      wait_cnt <= 4'h0;
      cs_n_reg <= 1'b1;
      slot_l   <= 3'h0;
    end else begin
      case (lstate)
        cbl_pkg::CBL_IDLE: begin
          copy_reg <= 2'h0;
          if (st_s2 != st_seen) begin
            st_seen  <= st_s2;
            slot_l   <= slot_reg; // stable since release
            lstate   <= cbl_pkg::CBL_LEAD;
            cs_n_reg <= 1'b0;
            wait_cnt <= 4'h0;
          end
        end
        cbl_pkg::CBL_LEAD: begin
          wait_cnt <= wait_cnt + 4'h1;
          if (wait_cnt == 4'(`CBL_CS_LEAD_CYC - 1)) lstate <= cbl_pkg::CBL_XFER;
        end
        cbl_pkg::CBL_XFER: begin
          wait_cnt <= 4'h0;
          if (sck_fall && bit_cnt == BW'(TOTAL - 1)) lstate <= cbl_pkg::CBL_HOLD;
        end
        cbl_pkg::CBL_HOLD: begin
          wait_cnt <= wait_cnt + 4'h1;
          if (wait_cnt == 4'(`CBL_CS_HOLD_CYC - 1)) begin
            cs_n_reg <= 1'b1;
            wait_cnt <= 4'h0;
            lstate   <= cbl_pkg::CBL_GAP;
          end
        end
        default: begin
          wait_cnt <= wait_cnt + 4'h1;
          if (wait_cnt == 4'(`CBL_CS_HIGH_CYC - 1)) begin
            wait_cnt <= 4'h0;
            if (copy_reg == `CBL_LAST_COPY) begin
              lstate <= cbl_pkg::CBL_IDLE;
            end else begin
              copy_reg <= copy_reg + 2'h1;
              cs_n_reg <= 1'b0;
              lstate   <= cbl_pkg::CBL_LEAD;
            end
          end
        end
      endcase
    end
  end

  // Clock divider from the oscillator
  always_ff @(posedge clk_osc) begin
    if (!ors2 || lstate != cbl_pkg::CBL_XFER) begin
      hc      <= 4'h0;
      sck_reg <= 1'b0;
    end else if (!stall) begin
      hc <= (hc == 4'(HALF - 1)) ? 4'h0 : hc + 4'h1;
      if (sck_tick) sck_reg <= ~sck_reg;
    end
  end

  // Command and address out, MSB first, advanced on falling edges
  always_ff @(posedge clk_osc) begin
    if (!ors2) begin
      tx_shift <= '0;
      bit_cnt  <= '0;
    end else if (lstate != cbl_pkg::CBL_XFER) begin
      tx_shift <= {READ_CMD, ee_addr};
      bit_cnt  <= '0;
    end else if (sck_fall) begin
      tx_shift <= {tx_shift[HDR-2:0], 1'b0};
      bit_cnt  <= bit_cnt + BW'(1);
    end
  end

  // Data in on rising edges, one handshake per byte
  always_ff @(posedge clk_osc) begin
    if (!ors2) begin
      rx_shift <= 8'h00;
      req_tog  <= 1'b0;
      rx_word  <= '0;
    end else if (sck_rise && data_phase) begin
      rx_shift <= {rx_shift[6:0], mi_s2};
      if (bit_cnt[2:0] == 3'h7) begin
        rx_word <= '{copy: copy_reg, offset: 5'(data_idx >> 3), data: {rx_shift[6:0], mi_s2}};
        req_tog <= ~req_tog;
      end
    end
  end

  assign ee_cs_n = cs_n_reg;
  assign ee_sck  = sck_reg;
  assign ee_mosi = tx_shift[HDR-1];

  // ---------------- assertions, system domain ----------------
  a_slot_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rel_pulse |=> slot_reg == $past(sel_s2)) else $error("slot not latched at release");

  a_slot_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rel_pulse |=> $stable(slot_reg)) else $error("slot changed after release");

  a_fetch_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rel_pulse && ifs_s2 |=> start_tog_reg != $past(start_tog_reg))
    else $error("no fetch started on release");

  a_first_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take_last && rx_word.copy == 2'h0 |=> ##1 stat_reg.loaded
      && cfg_reg[NUM_REGS-1] == $past(rx_word.data, 2))
    else $error("first copy not applied");

  sequence s_third_done;
    take_last && rx_word.copy == `CBL_LAST_COPY;
  endsequence

  a_vote_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_third_done |=> ##1 stat_reg.voted && cfg_reg[0] == ((copy_a[0] & copy_b[0])
      | (copy_a[0] & copy_c[0]) | (copy_b[0] & copy_c[0])))
    else $error("majority vote not applied");

  a_cfg_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !apply0_reg && !apply2_reg |=> $stable(cfg_reg))
    else $error("registers changed outside an apply");

  a_active_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(act_reg) |-> $past(apply0_reg || apply2_reg) && act_reg == cfg_reg[0][`CBL_ACT_BIT])
    else $error("activation bit out of step");

  // ---------------- assertions, link domain ----------------
  a_idle_cs: assert property (@(posedge clk_osc) disable iff (!ors2 || !rst_n)
    lstate == cbl_pkg::CBL_IDLE |-> cs_n_reg && !sck_reg) else $error("select low while idle");

  a_burst_addr: assert property (@(posedge clk_osc) disable iff (!ors2)
    $past(lstate) == cbl_pkg::CBL_LEAD |-> tx_shift[ADDR_W-1:0] == ADDR_W'(slot_l) * ADDR_W'(64)
      + ((copy_reg == 2'h0) ? ADDR_W'(0) : (copy_reg == 2'h1) ? ADDR_W'(20) : ADDR_W'(40)))
    else $error("wrong burst start address");

  a_burst_len: assert property (@(posedge clk_osc) disable iff (!ors2)
    lstate == cbl_pkg::CBL_XFER ##1 lstate == cbl_pkg::CBL_HOLD |-> $past(bit_cnt) == BW'(TOTAL - 1))
    else $error("burst ended at wrong length");

  a_sck_rate: assert property (@(posedge clk_osc) disable iff (!ors2)
    $rose(sck_reg) |-> sck_reg[*4] ##1 !sck_reg) else $error("serial clock off rate");

endmodule // cbl_loader

// ---- cbl_pkg.sv ----
/*
  Types of the boot-time configuration loader.
  Assumes cbl_defs.svh is compiled alongside for the numeric constants.
*/
package cbl_pkg;

  // One configuration byte
  typedef logic [7:0] cbl_byte_t;

  // Slot selection pins, high/mid/low form the binary index
  typedef struct packed {
    logic high;
    logic mid;
    logic low;
  } cbl_sel_t;

  // Byte handed from the link domain to the system domain
  typedef struct packed {
    logic [1:0] copy;
    logic [4:0] offset;
    cbl_byte_t  data;
  } cbl_rx_byte_t;

  // Loader status seen by the rest of the device
  typedef struct packed {
    logic busy;
    logic loaded;
    logic voted;
  } cbl_status_t;

  // Link-side burst sequencer
  typedef enum {
    CBL_IDLE,
    CBL_LEAD,
    CBL_XFER,
    CBL_HOLD,
    CBL_GAP
  } cbl_link_state_t;

endpackage

// ---- testbench.sv ----
/*
  Self-checking bench of the configuration loader with an EEPROM model.
  Assumes cbl_defs.svh and cbl_pkg are compiled first.
*/
`timescale 1ns/1ps
`include "cbl_defs.svh"

module testbench;
  localparam int N     = `CBL_NUM_REGS;
  localparam int LIMIT = 100000;
  typedef logic [N-1:0][7:0] cbl_tb_cfg_t;
  typedef struct packed {
    cbl_tb_cfg_t cfg;
    logic        act;
    logic [2:0]  idx;
    logic [15:0] starts;
  } cbl_tb_cfg_note_t;

  logic                 clk_sys = 1'b0;
  logic                 clk_osc = 1'b0;
  logic                 rst_n   = 1'b0;
  logic                 sel_high = 1'b0;
  logic                 sel_mid  = 1'b0;
  logic                 sel_low  = 1'b0;
  logic                 if_sel   = 1'b0;
  logic                 ee_cs_n, ee_sck, ee_mosi, ee_miso, activation_bit;
  cbl_tb_cfg_t          cfg_regs;
  cbl_pkg::cbl_status_t status, status_prev;
  logic [2:0]           slot_index;
  logic [7:0]           cmd_seen;
  logic [15:0]          addr_seen, bits_seen, n_starts;
  int                   error_cnt = 0;
  int                   checks = 0;
  int                   cyc = 0;
  logic [31:0]          lfsr = 32'h3a35acc9;
  bit                   link_ignore = 1'b0;
  real                  t_rise = 0.0;
  logic [39:0]          q_link [$];
  cbl_tb_cfg_note_t     q_cfg [$];

  // Clocks, the oscillator unrelated in phase
  always #12.5 clk_sys = ~clk_sys;
  always #32 clk_osc = ~clk_osc;

  cbl_loader uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_osc(clk_osc),
    .config_sel_high(sel_high), .config_sel_mid(sel_mid), .config_sel_low(sel_low),
    .interface_select_pin(if_sel),
    .ee_cs_n(ee_cs_n), .ee_sck(ee_sck), .ee_mosi(ee_mosi), .ee_miso(ee_miso),
    .cfg_regs(cfg_regs), .activation_bit(activation_bit), .status(status),
    .slot_index(slot_index)
  );

  cbl_eeprom_model ee (
    .cs_n(ee_cs_n), .sck(ee_sck), .mosi(ee_mosi), .miso(ee_miso),
    .cmd_seen(cmd_seen), .addr_seen(addr_seen), .bits_seen(bits_seen),
    .n_starts(n_starts)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One reset release on a slot, optionally aborted mid first copy
  task automatic run_slot(input logic [2:0] idx, input bit abort);
    cbl_tb_cfg_t c0, c1, c2, v;
    int          base, n, k;
    base = 64 * int'(idx);
    for (k = 0; k < N; k++) begin
      lfsr = lfsr_next(lfsr);
      c0[k] = lfsr[7:0];
      c1[k] = lfsr[7:0] ^ lfsr[15:8];
      c2[k] = lfsr[7:0] ^ lfsr[23:16];
      ee.mem[base + k] = c0[k];
      ee.mem[base + 20 + k] = c1[k];
      ee.mem[base + 40 + k] = c2[k];
    end
    v = (c0 & c1) | (c0 & c2) | (c1 & c2);
    @(negedge clk_sys);
    rst_n = 1'b0;
    {sel_high, sel_mid, sel_low} = idx;
    repeat (40) @(negedge clk_sys);
    q_link.delete();
    q_cfg.delete();
    link_ignore = 1'b0;
    n = int'(n_starts);
    for (k = 0; k < 3; k++) q_link.push_back({`CBL_READ_CMD, 16'(base + 20 * k), 16'h00b0});
    q_cfg.push_back({c0, c0[0][`CBL_ACT_BIT], idx, 16'(n + 1)});
    q_cfg.push_back({v, v[0][`CBL_ACT_BIT], idx, 16'(n + 3)});
    rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    lfsr = lfsr_next(lfsr);
    {sel_high, sel_mid, sel_low} = lfsr[2:0];
    if (abort) begin
      repeat (1000) @(negedge clk_sys);
      link_ignore = 1'b1;
    end else begin
      k = 0;
      while (status.voted !== 1'b1 && k < 20000) begin
        @(negedge clk_sys);
        k++;
      end
      repeat (40) @(negedge clk_sys);
      check(256'({status, slot_index}), 256'({3'h3, idx}));
      check(256'({q_link.size(), q_cfg.size()}), 256'h0);
    end
  endtask

  // Timeout guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("ERROR at %0t: cycles %h limit %h", $time, cyc, LIMIT);
      report_and_stop();
    end
  end

  // End of each burst takes the oldest link note
  always @(posedge ee_cs_n) begin
    if (rst_n === 1'b1 && !link_ignore) begin
      if (q_link.size() == 0) check(256'h1, 256'h0);
      else check(256'({cmd_seen, addr_seen, bits_seen}), 256'(q_link.pop_front()));
    end
  end

  // High phase of the serial clock
  always @(posedge ee_sck) t_rise = $realtime;
  always @(negedge ee_sck) begin
    if (ee_cs_n === 1'b0 && rst_n === 1'b1) check(256'(int'($realtime - t_rise)), 256'h100);
  end

  // Each load or vote takes the oldest register note, on settled values
  always @(negedge clk_sys) begin
    status_prev <= status;
    if (rst_n && ((status.loaded && !status_prev.loaded) ||
                  (status.voted && !status_prev.voted))) begin
      if (q_cfg.size() == 0) check(256'h1, 256'h0);
      else check(256'({cfg_regs, activation_bit, slot_index, n_starts}), 256'(q_cfg.pop_front()));
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (400) @(negedge clk_sys);
    check(256'({n_starts, status, cfg_regs}), 256'h0);
    if_sel = 1'b1;
    run_slot(3'h5, 1'b1);
    for (int i = 0; i < 8; i++) run_slot(3'(i), 1'b0);
    report_and_stop();
  end
endmodule // testbench
